/* dv/apb_requester.sv */
// apb master model standing on the register side of the unit
// assumes one pclk domain; transfers are requested through xfer
`timescale 1ns/1ps

module apb_requester (
  // clock
  input wire logic pclk,
  // request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  // answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end

  // setup, then access held until pready is sampled high or 20 access cycles have passed
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output bit to);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    to = (n >= 20);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

/* dv/exec_group_sva.sv */
// checker for the execution unit's apb answer and busy/skip timing
// assumes it is bound to exec_group and sees only its ports
`timescale 1ns/1ps

module exec_group_sva
  import exec_group_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // status
  input wire logic busy,
  input wire logic skip_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside answer");
  a_err_unmapped: assert property (pready && (paddr[31:8] != 24'h0 || paddr[1:0] != 2'h0)
    |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_cmd_reads_zero: assert property (pready && !pwrite && paddr == {24'h0, OFS_CMD} |-> prdata == 32'h0 && !pslverr)
    else $error("command register read not zero");
  a_busy_after_cmd: assert property (pready && psel && penable && pwrite && !busy
    && paddr == {24'h0, OFS_CMD} |=> busy)
    else $error("busy did not follow command");
  a_busy_one_cycle: assert property ($rose(busy) |-> !skip_pulse ##1 (!busy || skip_pulse))
    else $error("operation longer than one cycle");
  a_skip_in_busy: assert property (skip_pulse |-> busy && $past(busy))
    else $error("dummy cycle outside operation");
  a_skip_two_cycles: assert property (skip_pulse |=> !busy && !skip_pulse)
    else $error("dummy cycle not single");
endmodule

/* dv/tb_top.sv */
// self-checking bench for the execution unit through its registers
// assumes the apb_requester model and the bound checker
`timescale 1ns/1ps

module tb_top;
  import exec_group_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy, skip_pulse;
  logic [31:0] paddr, pwdata, prdata, c0;
  logic [7:0] av [4] = '{8'h10, 8'h80, 8'h33, 8'h25};
  logic [7:0] bv [4] = '{8'h20, 8'h01, 8'h33, 8'h17};
  logic [3:0] so [6] = '{OP_SKIP_ON_NIL, OP_SKIP_ON_NIL, OP_COPY_SKIP_ON_NIL, OP_COPY_SKIP_ON_NIL,
                        OP_SKIP_ON_NIL_BIT, OP_SKIP_ON_NIL_BIT};
  logic [7:0] sv [6] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'hfb, 8'hfb};
  logic [2:0] sb [6] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h3};
  logic sk [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
  int failures, check_count;

  exec_group uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy), .skip_pulse(skip_pulse));
  apb_requester bus (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    logic er;
    bit to;
    bus.xfer(w, {24'h0, a}, d, r, er, to);
    if (to)
    begin
      failures++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    acc(1'b1, a, d, r);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    acc(1'b0, a, 32'h0, r);
    chk(r, x);
  endtask

  // access that must be refused: error flag set, read data zero
  task automatic rerr(input logic w, input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic er;
    bit to;
    bus.xfer(w, a, d, r, er, to);
    if (to)
    begin
      failures++;
      stop_test();
    end
    chk({31'h0, er}, 32'h1);
    chk(r, 32'h0);
  endtask

  task automatic setm(input logic [5:0] m, input logic [7:0] d);
    wr(OFS_DMEM_ADDR, {26'h0, m});
    wr(OFS_DMEM_DATA, {24'h0, d});
  endtask

  task automatic rcm(input logic [5:0] m, input logic [7:0] x);
    wr(OFS_DMEM_ADDR, {26'h0, m});
    rc(OFS_DMEM_DATA, {24'h0, x});
  endtask

  task automatic op(input logic [3:0] o, input logic [5:0] m, input logic [7:0] i, input logic [2:0] b);
    logic [31:0] r;
    int n;
    wr(OFS_CMD, {5'h0, b, i, 2'h0, m, 4'h0, o});
    n = 0;
    do
    begin
      acc(1'b0, OFS_STATUS, 32'h0, r);
      n++;
    end
    while (r[STS_BUSY] !== 1'b0 && n < 8);
    if (n >= 8)
    begin
      failures++;
      stop_test();
    end
  endtask

  // expected {wrap, nil, nibble borrow, no borrow} of a - b
  function automatic logic [31:0] sflg(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    r = a - b;
    return {28'h0, (a[7] != b[7]) && (r[7] != a[7]), r == 8'h00, a[3:0] < b[3:0], a >= b};
  endfunction

  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial
  begin
    presetn = 1'b0;
    failures = 0;
    check_count = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rc(OFS_ACC, 32'h0);
    rc(OFS_STATUS, 32'h0);
    rc(OFS_CMD, 32'h0);
    rerr(1'b0, 32'h30, 32'h0);
    rerr(1'b0, 32'h5, 32'h0);
    rerr(1'b1, 32'h104, 32'h77);
    rc(OFS_ACC, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(OFS_ACC, {24'h0, av[i]});
      setm(6'h05, bv[i]);
      op(OP_MINUS_TO_MEM, 6'h05, 8'h00, 3'h0);
      rcm(6'h05, av[i] - bv[i]);
      rc(OFS_STATUS, sflg(av[i], bv[i]));
      op(OP_MINUS_TO_ACC, 6'h00, bv[i], 3'h0);
      rc(OFS_ACC, {24'h0, av[i] - bv[i]});
      rc(OFS_STATUS, sflg(av[i], bv[i]));
    end
    wr(OFS_STATUS, 32'ha);
    setm(6'h07, 8'h5a);
    op(OP_NIBBLE_EXCHANGE, 6'h07, 8'h00, 3'h0);
    rcm(6'h07, 8'ha5);
    rc(OFS_STATUS, 32'ha);
    setm(6'h08, 8'h3c);
    op(OP_NIBBLE_EXCHANGE_TO_ACC, 6'h08, 8'h00, 3'h0);
    rc(OFS_ACC, 32'hc3);
    rcm(6'h08, 8'h3c);
    for (int i = 0; i < 6; i++)
    begin
      wr(OFS_ACC, 32'h55);
      setm(6'h09, sv[i]);
      acc(1'b0, OFS_CYCLES, 32'h0, c0);
      op(so[i], 6'h09, 8'h00, sb[i]);
      rc(OFS_STATUS, {22'h0, sk[i], 5'h0, 4'ha});
      rc(OFS_CYCLES, c0 + 32'h1 + {31'h0, sk[i]});
      rc(OFS_ACC, (so[i] == OP_COPY_SKIP_ON_NIL) ? {24'h0, sv[i]} : 32'h55);
    end
    for (int p = 0; p < 4; p++)
    begin
      wr(OFS_PMEM_ADDR, 32'h11 + 32'h100 * p);
      wr(OFS_PMEM_DATA, 32'h9040 + 32'h101 * p);
    end
    wr(OFS_PTR_HIGH, 32'h2);
    wr(OFS_PTR_LOW, 32'h11);
    wr(OFS_PC_PAGE, 32'h1);
    rc(OFS_PTR_HIGH, 32'h2);
    rc(OFS_PTR_LOW, 32'h11);
    rc(OFS_PC_PAGE, 32'h1);
    rc(OFS_PMEM_ADDR, 32'h311);
    rc(OFS_PMEM_DATA, 32'h9343);
    for (int k = 0; k < 3; k++)
    begin
      op(OP_ROM_FETCH_PAGED + 4'(k), 6'h0a, 8'h00, 3'h0);
      rcm(6'h0a, 8'h40 + 8'((k == 0) ? 2 : (k == 1) ? 1 : 3));
      rc(OFS_HIGH_LATCH, 32'h90 + ((k == 0) ? 2 : (k == 1) ? 1 : 3));
    end
    wr(OFS_STATUS, 32'hb);
    wr(OFS_ACC, 32'h3c);
    setm(6'h0b, 8'h3c);
    op(OP_XOR_TO_ACC, 6'h0b, 8'h00, 3'h0);
    rc(OFS_ACC, 32'h0);
    rc(OFS_STATUS, 32'hf);
    wr(OFS_ACC, 32'h0f);
    setm(6'h0c, 8'hf0);
    op(OP_XOR_INTO_MEM, 6'h0c, 8'h00, 3'h0);
    rcm(6'h0c, 8'hff);
    rc(OFS_STATUS, 32'hb);
    rc(OFS_ACC, 32'h0f);
    op(OP_XOR_IMM, 6'h00, 8'h0f, 3'h0);
    rc(OFS_ACC, 32'h0);
    rc(OFS_STATUS, 32'hf);
    acc(1'b0, OFS_CYCLES, 32'h0, c0);
    op(4'he, 6'h0c, 8'h55, 3'h0);
    rc(OFS_ACC, 32'h0);
    rc(OFS_STATUS, 32'hf);
    rcm(6'h0c, 8'hff);
    rc(OFS_CYCLES, c0 + 32'h1);
    stop_test();
  end
endmodule

bind exec_group exec_group_sva chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busy(busy), .skip_pulse(skip_pulse));

/* rtl/exec_group.sv */
// execution unit for subtract, nibble swap, zero skips, table reads and xor
// assumes an apb master on pclk; data and program memory live inside

`timescale 1ns/1ps

module exec_group
  import exec_group_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // execution status
  output logic busy,
  output logic skip_pulse
);
  import exec_group_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] dmem [DMEM_DEPTH];
  logic [PWORD_W-1:0] pmem [PMEM_DEPTH];
  exec_state_e state_q;
  logic [3:0] op_q;
  logic [DMEM_AW-1:0] maddr_q;
  logic [7:0] imm_q;
  logic [2:0] bit_q;
  logic [7:0] acc_q;
  logic [3:0] flags_q;
  logic [7:0] ptr_low_q;
  logic [7:0] ptr_high_q;
  logic [7:0] high_latch_q;
  logic [PAGE_W-1:0] pc_page_q;
  logic [DMEM_AW-1:0] dmem_addr_q;
  logic [PMEM_AW-1:0] pmem_addr_q;
  logic [31:0] cycles_q;
  logic skip_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic busy_q;
  logic skip_pulse_q;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  logic acc_phase;
  logic wr_done;
  logic [7:0] ofs;
  logic mapped;

  assign acc_phase = psel & penable;
  // an unmapped write, upper address bits included, must not alias a register
  assign wr_done = acc_phase & pready_q & pwrite & mapped;
  assign ofs = paddr[7:0];

  always_comb
  begin
    mapped = 1'b0;
    if (paddr[31:8] != 24'h000000 || paddr[1:0] != 2'h0)
      mapped = 1'b0;
    else if (ofs == OFS_CMD || ofs == OFS_ACC || ofs == OFS_STATUS || ofs == OFS_PTR_LOW)
      mapped = 1'b1;
    else if (ofs == OFS_PTR_HIGH || ofs == OFS_HIGH_LATCH || ofs == OFS_PC_PAGE)
      mapped = 1'b1;
    else if (ofs == OFS_DMEM_ADDR || ofs == OFS_DMEM_DATA || ofs == OFS_PMEM_ADDR)
      mapped = 1'b1;
    else if (ofs == OFS_PMEM_DATA || ofs == OFS_CYCLES)
      mapped = 1'b1;
  end

  logic [31:0] rdata_d;

  always_comb
  begin
    rdata_d = RST_WORD;
    if (ofs == OFS_ACC)
      rdata_d = {24'h000000, acc_q};
    else if (ofs == OFS_STATUS)
      rdata_d = {22'h000000, skip_q, busy_q, 4'h0, flags_q};
    else if (ofs == OFS_PTR_LOW)
      rdata_d = {24'h000000, ptr_low_q};
    else if (ofs == OFS_PTR_HIGH)
      rdata_d = {24'h000000, ptr_high_q};
    else if (ofs == OFS_HIGH_LATCH)
      rdata_d = {24'h000000, high_latch_q};
    else if (ofs == OFS_PC_PAGE)
      rdata_d = {30'h00000000, pc_page_q};
    else if (ofs == OFS_DMEM_ADDR)
      rdata_d = {26'h0000000, dmem_addr_q};
    else if (ofs == OFS_DMEM_DATA)
      rdata_d = {24'h000000, dmem[dmem_addr_q]};
    else if (ofs == OFS_PMEM_ADDR)
      rdata_d = {22'h000000, pmem_addr_q};
    else if (ofs == OFS_PMEM_DATA)
      rdata_d = {16'h0000, pmem[pmem_addr_q]};
    else if (ofs == OFS_CYCLES)
      rdata_d = cycles_q;
  end

  // one wait state: pready rises in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      prdata_q <= RST_WORD;
      pslverr_q <= 1'b0;
    end
    else if (acc_phase && !pready_q)
    begin
      pready_q <= 1'b1;
      prdata_q <= (mapped && !pwrite) ? rdata_d : RST_WORD;
      pslverr_q <= ~mapped;
    end
    else
    begin
      pready_q <= 1'b0;
      prdata_q <= RST_WORD;
      pslverr_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // datapath
  // ---------------------------------------------------------------
  logic [7:0] mval;
  logic [7:0] sub_b;
  logic [8:0] diff;
  logic [4:0] half;
  logic [7:0] xor_b;
  logic [7:0] xres;
  logic [PMEM_AW-1:0] taddr;
  logic [PWORD_W-1:0] tword;
  logic is_sub;
  logic is_xor;
  logic skip_d;

  assign mval = dmem[maddr_q];
  assign sub_b = (op_q == OP_MINUS_TO_ACC) ? imm_q : mval;
  assign diff = {1'b0, acc_q} - {1'b0, sub_b};
  assign half = {1'b0, acc_q[3:0]} - {1'b0, sub_b[3:0]};
  assign xor_b = (op_q == OP_XOR_IMM) ? imm_q : mval;
  assign xres = acc_q ^ xor_b;
  assign is_sub = (op_q == OP_MINUS_TO_MEM) || (op_q == OP_MINUS_TO_ACC);
  assign is_xor = (op_q == OP_XOR_TO_ACC) || (op_q == OP_XOR_INTO_MEM) || (op_q == OP_XOR_IMM);
  assign tword = pmem[taddr];

  always_comb
  begin
    taddr = {ptr_high_q[PAGE_W-1:0], ptr_low_q};
    if (op_q == OP_ROM_FETCH_CURRENT_PAGE)
      taddr = {pc_page_q, ptr_low_q};
    else if (op_q == OP_ROM_FETCH_LAST_PAGE)
      taddr = {LAST_PAGE, ptr_low_q};
  end

  always_comb
  begin
    skip_d = 1'b0;
    if (op_q == OP_SKIP_ON_NIL || op_q == OP_COPY_SKIP_ON_NIL)
      skip_d = (mval == 8'h00);
    else if (op_q == OP_SKIP_ON_NIL_BIT)
      skip_d = ~mval[bit_q];
  end

  logic executing;
  assign executing = (state_q == st_exec);

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= st_idle;
      op_q <= 4'h0;
      maddr_q <= '0;
      imm_q <= RST_BYTE;
      bit_q <= 3'h0;
      skip_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        st_idle:
          if (wr_done && ofs == OFS_CMD)
          begin
            op_q <= pwdata[CMD_OP_LSB +: 4];
            maddr_q <= pwdata[CMD_ADDR_LSB +: DMEM_AW];
            imm_q <= pwdata[CMD_IMM_LSB +: 8];
            bit_q <= pwdata[CMD_BIT_LSB +: 3];
            state_q <= st_exec;
          end
        st_exec:
        begin
          skip_q <= skip_d;
          state_q <= skip_d ? st_dummy : st_idle;
        end
        st_dummy:
          state_q <= st_idle;
        default:
          state_q <= st_idle;
      endcase
    end
  end

  // busy covers the execute cycle and any dummy cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      busy_q <= 1'b0;
      skip_pulse_q <= 1'b0;
    end
    else
    begin
      busy_q <= (state_q == st_idle) ? (wr_done && ofs == OFS_CMD) : (executing && skip_d);
      skip_pulse_q <= executing && skip_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cycles_q <= RST_WORD;
    else if (state_q != st_idle)
      cycles_q <= cycles_q + 32'h0000_0001;
  end

  // ---------------------------------------------------------------
  // accumulator and flags
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      acc_q <= RST_BYTE;
    else if (executing && op_q == OP_MINUS_TO_ACC)
      acc_q <= diff[7:0];
    else if (executing && op_q == OP_NIBBLE_EXCHANGE_TO_ACC)
      acc_q <= {mval[3:0], mval[7:4]};
    else if (executing && op_q == OP_COPY_SKIP_ON_NIL)
      acc_q <= mval;
    else if (executing && (op_q == OP_XOR_TO_ACC || op_q == OP_XOR_IMM))
      acc_q <= xres;
    else if (wr_done && ofs == OFS_ACC && state_q == st_idle)
      acc_q <= pwdata[7:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_q <= RST_FLAGS;
    else if (executing && is_sub)
    begin
      flags_q[FLG_BORROW_INV] <= ~diff[8];
      flags_q[FLG_NIBBLE] <= half[4];
      flags_q[FLG_NIL] <= (diff[7:0] == 8'h00);
      flags_q[FLG_WRAP] <= (acc_q[7] ^ sub_b[7]) & (acc_q[7] ^ diff[7]);
    end
    else if (executing && is_xor)
      flags_q[FLG_NIL] <= (xres == 8'h00);
    else if (wr_done && ofs == OFS_STATUS && state_q == st_idle)
      flags_q <= pwdata[3:0];
  end

  // ---------------------------------------------------------------
  // data memory, table pointers and latch
  // ---------------------------------------------------------------
  always_ff @(posedge pclk)
  begin
    if (executing && op_q == OP_MINUS_TO_MEM)
      dmem[maddr_q] <= diff[7:0];
    else if (executing && op_q == OP_NIBBLE_EXCHANGE)
      dmem[maddr_q] <= {mval[3:0], mval[7:4]};
    else if (executing && op_q == OP_XOR_INTO_MEM)
      dmem[maddr_q] <= xres;
    else if (executing && (op_q == OP_ROM_FETCH_PAGED || op_q == OP_ROM_FETCH_CURRENT_PAGE
             || op_q == OP_ROM_FETCH_LAST_PAGE))
      dmem[maddr_q] <= tword[7:0];
    else if (wr_done && ofs == OFS_DMEM_DATA)
      dmem[dmem_addr_q] <= pwdata[7:0];
  end

  always_ff @(posedge pclk)
  begin
    if (wr_done && ofs == OFS_PMEM_DATA)
      pmem[pmem_addr_q] <= pwdata[PWORD_W-1:0];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      high_latch_q <= RST_BYTE;
    else if (executing && (op_q == OP_ROM_FETCH_PAGED || op_q == OP_ROM_FETCH_CURRENT_PAGE
             || op_q == OP_ROM_FETCH_LAST_PAGE))
      high_latch_q <= tword[15:8];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ptr_low_q <= RST_BYTE;
      ptr_high_q <= RST_BYTE;
      pc_page_q <= '0;
      dmem_addr_q <= '0;
      pmem_addr_q <= '0;
    end
    else if (wr_done)
    begin
      if (ofs == OFS_PTR_LOW)
        ptr_low_q <= pwdata[7:0];
      else if (ofs == OFS_PTR_HIGH)
        ptr_high_q <= pwdata[7:0];
      else if (ofs == OFS_PC_PAGE)
        pc_page_q <= pwdata[PAGE_W-1:0];
      else if (ofs == OFS_DMEM_ADDR)
        dmem_addr_q <= pwdata[DMEM_AW-1:0];
      else if (ofs == OFS_PMEM_ADDR)
        pmem_addr_q <= pwdata[PMEM_AW-1:0];
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign busy = busy_q;
  assign skip_pulse = skip_pulse_q;

endmodule

/* rtl/exec_group_pkg.sv */
// constants for the subtract, swap, skip, table-read and xor execution unit
// assumes a 32-bit apb master on pclk and a single clock domain

package exec_group_pkg;

  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int DMEM_AW = 6;
  localparam int DMEM_DEPTH = 64;
  localparam int PWORD_W = 16;
  localparam int PAGE_W = 2;
  localparam int PMEM_AW = 10;
  localparam int PMEM_DEPTH = 1024;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_PTR_LOW = 8'h0c;
  localparam logic [7:0] OFS_PTR_HIGH = 8'h10;
  localparam logic [7:0] OFS_HIGH_LATCH = 8'h14;
  localparam logic [7:0] OFS_PC_PAGE = 8'h18;
  localparam logic [7:0] OFS_DMEM_ADDR = 8'h1c;
  localparam logic [7:0] OFS_DMEM_DATA = 8'h20;
  localparam logic [7:0] OFS_PMEM_ADDR = 8'h24;
  localparam logic [7:0] OFS_PMEM_DATA = 8'h28;
  localparam logic [7:0] OFS_CYCLES = 8'h2c;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_IMM_LSB = 16;
  localparam int CMD_BIT_LSB = 24;
  localparam int FLG_BORROW_INV = 0;
  localparam int FLG_NIBBLE = 1;
  localparam int FLG_NIL = 2;
  localparam int FLG_WRAP = 3;
  localparam int STS_BUSY = 8;
  localparam int STS_SKIP = 9;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ---------------------------------------------------------------
  // operation codes of the command register
  // ---------------------------------------------------------------
  localparam logic [3:0] OP_MINUS_TO_MEM = 4'h1;
  localparam logic [3:0] OP_MINUS_TO_ACC = 4'h2;
  localparam logic [3:0] OP_NIBBLE_EXCHANGE = 4'h3;
  localparam logic [3:0] OP_NIBBLE_EXCHANGE_TO_ACC = 4'h4;
  localparam logic [3:0] OP_SKIP_ON_NIL = 4'h5;
  localparam logic [3:0] OP_COPY_SKIP_ON_NIL = 4'h6;
  localparam logic [3:0] OP_SKIP_ON_NIL_BIT = 4'h7;
  localparam logic [3:0] OP_ROM_FETCH_PAGED = 4'h8;
  localparam logic [3:0] OP_ROM_FETCH_CURRENT_PAGE = 4'h9;
  localparam logic [3:0] OP_ROM_FETCH_LAST_PAGE = 4'ha;
  localparam logic [3:0] OP_XOR_TO_ACC = 4'hb;
  localparam logic [3:0] OP_XOR_INTO_MEM = 4'hc;
  localparam logic [3:0] OP_XOR_IMM = 4'hd;

  localparam logic [1:0] LAST_PAGE = 2'h3;

  typedef enum logic [1:0] {st_idle, st_exec, st_dummy} exec_state_e;

endpackage
